// ---- sbs_map.svh ----
// Constants for the synchronous burst SRAM port: widths, layout and reset values
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// Array shape, 128K words of four byte lanes plus per-lane parity
`define SBS_ADDR_W 17
`define SBS_UPPER_W 15
`define SBS_DEPTH 131072
`define SBS_LANES 4
`define SBS_BYTE_W 8
`define SBS_WORD_W 36
`define SBS_PAR_LSB 32
// Parity storage present; clear this for the parity-free width
`define SBS_HAS_PARITY 1'b1
// Lanes wired in this width; the narrow width would use 4'h3
`define SBS_LANES_USED 4'hf
// Burst counter
`define SBS_CNT_W 2
`define SBS_CNT_ZERO 2'h0
`define SBS_CNT_STEP 2'h1
// Reset values
`define SBS_WORD_RST 36'h0_0000_0000
`define SBS_UPPER_RST 15'h0000

`endif

// ---- sbs_pkg.sv ----
// Types and helper functions shared by the SRAM port modules
`default_nettype none
`include "sbs_map.svh"

package sbs_pkg;

  typedef logic [`SBS_WORD_W-1:0] sbs_word_t;
  typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
  typedef logic [`SBS_LANES-1:0] sbs_lanes_t;
  typedef logic [`SBS_CNT_W-1:0] sbs_cnt_t;

  // Port modes
  typedef enum logic [1:0] {
    SBS_IDLE = 2'b00,
    SBS_BURST = 2'b01,
    SBS_SLEEP = 2'b10
  } sbs_mode_t;

  // Whole state of the port control logic
  typedef struct packed {
    sbs_mode_t mode;
    logic [`SBS_UPPER_W-1:0] upper;
    sbs_cnt_t start;
    sbs_cnt_t cnt;
    logic order;
    logic rd_pend;
    logic rd_valid;
    sbs_word_t dout;
  } sbs_state_t;

  // Low two address bits of burst step cnt from start; order high means interleaved
  function automatic sbs_cnt_t sbs_burst_low(input sbs_cnt_t start, input sbs_cnt_t cnt,
                                              input logic order);
    sbs_cnt_t low;
    if (order) begin
      low = start ^ cnt;
    end else begin
      low = sbs_cnt_t'(start + cnt);
    end
    return low;
  endfunction

  // Lanes written this edge; full write overrides the gate and lane enables
  function automatic sbs_lanes_t sbs_lane_mask(input logic full_n, input logic gate_n,
                                               input sbs_lanes_t lane_n);
    sbs_lanes_t m;
    if (!full_n) begin
      m = `SBS_LANES_USED;
    end else if (!gate_n) begin
      m = ~lane_n & `SBS_LANES_USED;
    end else begin
      m = '0;
    end
    return m;
  endfunction

  // Expand a lane mask to bit enables over the data byte and its parity bit
  function automatic sbs_word_t sbs_bit_mask(input sbs_lanes_t lanes);
    sbs_word_t m;
    m = '0;
    for (int i = 0; i < `SBS_LANES; i++) begin
      m[i*`SBS_BYTE_W +: `SBS_BYTE_W] = {`SBS_BYTE_W{lanes[i]}};
      m[`SBS_PAR_LSB + i] = lanes[i] & `SBS_HAS_PARITY;
    end
    return m;
  endfunction

endpackage

`default_nettype wire

// ---- sbs_mem_if.sv ----
// Carrier between the port control logic and the storage array
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

interface sbs_mem_if;
  logic en;
  logic rd_en;
  logic [`SBS_WORD_W-1:0] wr_mask;
  logic [`SBS_ADDR_W-1:0] addr;
  logic [`SBS_WORD_W-1:0] wdata;
  logic [`SBS_WORD_W-1:0] rdata;

  modport ctrl (output en, output rd_en, output wr_mask, output addr, output wdata,
                input rdata);
  modport mem (input en, input rd_en, input wr_mask, input addr, input wdata,
               output rdata);
endinterface

`default_nettype wire

// ---- sbs_array.sv ----
// Storage array with per-bit write enables and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_array
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  sbs_mem_if.mem m
);

  // Contents are never reset, so standby and reset both keep the data
  sbs_word_t mem_array [0:`SBS_DEPTH-1];
  sbs_word_t rdata_reg;
  sbs_word_t rdata_next;

  // Read returns the old word when the same address is written on that edge
  always_comb begin
    rdata_next = rdata_reg;
    if (m.rd_en) begin
      rdata_next = mem_array[m.addr];
    end
  end

  // Masked write; lanes without enable keep their bits
  always_ff @(posedge clk) begin
    if (m.en && (m.wr_mask != '0)) begin
      mem_array[m.addr] <= (mem_array[m.addr] & ~m.wr_mask) | (m.wdata & m.wr_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `SBS_WORD_RST;
    end else if (m.en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign m.rdata = rdata_reg;

endmodule // sbs_array

`default_nettype wire

// ---- sbs_sram_port.sv ----
// Pin-level control of a pipelined synchronous burst SRAM port
// Behaviour
// - Address bits are captured into the address register on the rising edge.
// - Each byte lane has its own active-low write enable.
// - Each lane enable gates its eight data bits and its parity bit.
// - Parity storage exists only in the 18- and 36-bit widths.
// - Lane writes happen only with the lane write gate also low.
// - Full write low writes every lane, whatever gate and lane enables say.
// - Address, data, selects, write enables and burst inputs register each edge.
// - Primary select enables the device and qualifies the processor strobe.
// - Primary select is sampled only on new address loads.
// - Selected only with second select low and third select high at load.
// - Sleep request enters standby and keeps array contents.
// - While sleep request is high all other inputs are ignored.
// - Output drivers follow the output drive input without the clock.
// - Burst step low after a load advances the burst counter.
// - Burst step high holds the burst address, a wait state.
// - Processor strobe aborts bursts, loads and reads; ignored with primary high.
// - Processor strobe with second or third select inactive powers down.
// - Controller strobe loads; read or write if primary low, else power-down.
// - Burst order low is linear, high interleaved; held constant.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_sram_port
  import sbs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic ADDR_BIT_ZERO,
  input wire logic ADDR_BIT_ONE,
  input wire logic [`SBS_UPPER_W-1:0] ADDR_UPPER_BITS,
  input wire logic LANE_A_WRITE_N,
  input wire logic LANE_B_WRITE_N,
  input wire logic LANE_C_WRITE_N,
  input wire logic LANE_D_WRITE_N,
  input wire logic LANE_WRITE_GATE_N,
  input wire logic FULL_WRITE_N,
  input wire logic PRIMARY_SELECT_N,
  input wire logic SECOND_SELECT_N,
  input wire logic THIRD_SELECT,
  input wire logic SLEEP_REQUEST,
  input wire logic OUTPUT_DRIVE_N,
  input wire logic BURST_STEP_N,
  input wire logic PROC_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_ORDER,
  input wire logic [`SBS_WORD_W-1:0] DATA_IN,
  output logic [`SBS_WORD_W-1:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic BURST_ACTIVE,
  output logic STANDBY
);

  sbs_state_t st_reg;
  sbs_state_t st_next;
  sbs_mem_if mif ();

  logic proc_load;
  logic ctrl_load;
  logic load;
  logic selected;
  sbs_lanes_t lane_n;
  sbs_lanes_t lanes;
  sbs_addr_t ext_addr;
  sbs_addr_t cur_addr;
  sbs_cnt_t step_cnt;

  sbs_array u_array (
    .clk(MCLK),
    .rst_n(RST_B),
    .m(mif)
  );

  // Lane enables gathered in lane order a to d
  assign lane_n = {LANE_D_WRITE_N, LANE_C_WRITE_N, LANE_B_WRITE_N, LANE_A_WRITE_N};

  // Strobe decode; the processor strobe only counts when primary select is low
  always_comb begin
    proc_load = !PROC_ADDR_STROBE_N && !PRIMARY_SELECT_N;
    ctrl_load = !CTRL_ADDR_STROBE_N && !proc_load;
    load = proc_load || ctrl_load;
    // Selects are looked at only when a load happens, never mid-burst
    selected = !PRIMARY_SELECT_N && !SECOND_SELECT_N && THIRD_SELECT;
  end

  // Write lanes; the narrow or parity-free widths mask out what they lack
  always_comb begin
    lanes = sbs_lane_mask(FULL_WRITE_N, LANE_WRITE_GATE_N, lane_n);
  end

  // External and current burst addresses
  always_comb begin
    ext_addr = {ADDR_UPPER_BITS, ADDR_BIT_ONE, ADDR_BIT_ZERO};
    cur_addr = {st_reg.upper, sbs_burst_low(st_reg.start, st_reg.cnt, st_reg.order)};
    step_cnt = sbs_cnt_t'(st_reg.cnt + `SBS_CNT_STEP);
  end

  // Access pipeline, one edge per stage:
  //   edge E   the array is asked for a word (load read, step or wait state)
  //   edge E+1 the array word moves into the output register and read valid rises
  //   until E+2 the data drivers may be on, if the drive input is low
  // Priority at each edge: sleep, then a processor load, then a controller load,
  // then burst continuation. Writes in continuation use the held burst address,
  // which is why the controller keeps the step input high right after a
  // processor-strobe load that turns into a write.
  // Hazard: a read and a write of one address on one edge return the old word,
  // so a controller must not expect write-through data.
  // Limitation: sleep is seen at clock edges here; only the driver disable is
  // immediate, which is all the far side can observe without a clock.
  // Next state and array requests; the strobes win over any running burst
  always_comb begin
    st_next = st_reg;
    mif.rd_en = 1'b0;
    mif.wr_mask = '0;
    mif.addr = cur_addr;
    mif.wdata = DATA_IN;
    // Read pipeline: the array word registered last edge moves to the output
    st_next.rd_pend = 1'b0;
    st_next.rd_valid = st_reg.rd_pend;
    if (st_reg.rd_pend) begin
      st_next.dout = mif.rdata;
    end
    if (SLEEP_REQUEST) begin
      // Standby drops any access but leaves the array alone
      st_next.mode = SBS_SLEEP;
      st_next.rd_valid = 1'b0;
    end else if (load) begin
      // New external address replaces whatever burst was going on
      st_next.upper = ext_addr[`SBS_ADDR_W-1:`SBS_CNT_W];
      st_next.start = ext_addr[`SBS_CNT_W-1:0];
      st_next.cnt = `SBS_CNT_ZERO;
      st_next.order = BURST_ORDER;
      mif.addr = ext_addr;
      if (!selected) begin
        st_next.mode = SBS_IDLE;
      end else begin
        st_next.mode = SBS_BURST;
        if (ctrl_load && (lanes != '0)) begin
          mif.wr_mask = sbs_bit_mask(lanes);
        end else begin
          // Processor strobe always reads, whatever the write inputs say
          mif.rd_en = 1'b1;
          st_next.rd_pend = 1'b1;
        end
      end
    end else begin
      case (st_reg.mode)
        SBS_BURST: begin
          if (lanes != '0) begin
            // Write lands on the held address; controller keeps step high here
            mif.wr_mask = sbs_bit_mask(lanes);
            if (!BURST_STEP_N) begin
              st_next.cnt = step_cnt;
            end
          end else if (!BURST_STEP_N) begin
            st_next.cnt = step_cnt;
            mif.addr = {st_reg.upper, sbs_burst_low(st_reg.start, step_cnt, st_reg.order)};
            mif.rd_en = 1'b1;
            st_next.rd_pend = 1'b1;
          end else begin
            // Wait state: same address read again, no advance
            mif.rd_en = 1'b1;
            st_next.rd_pend = 1'b1;
          end
        end
        SBS_SLEEP: begin
          // Waking leaves the port deselected until the next strobe
          st_next.mode = SBS_IDLE;
        end
        SBS_IDLE: begin
          st_next.mode = SBS_IDLE;
        end
        default: begin
          st_next.mode = SBS_IDLE;
        end
      endcase
    end
  end

  // Clock enable freezes the array along with the control state
  assign mif.en = CLK_EN;

  // Single state register; clock enable low holds everything
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg.mode <= SBS_IDLE;
      st_reg.upper <= `SBS_UPPER_RST;
      st_reg.start <= `SBS_CNT_ZERO;
      st_reg.cnt <= `SBS_CNT_ZERO;
      st_reg.order <= 1'b1;
      st_reg.rd_pend <= 1'b0;
      st_reg.rd_valid <= 1'b0;
      st_reg.dout <= `SBS_WORD_RST;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // Data and status come straight from the state register
  assign DATA_OUT = st_reg.dout;
  assign BURST_ACTIVE = st_reg.mode[0];
  assign STANDBY = st_reg.mode[1];

  // Driver enable is combinational so it answers the drive input with no clock;
  // sleep also turns the drivers off without waiting for an edge
  assign DATA_OE_N = OUTPUT_DRIVE_N | ~st_reg.rd_valid | SLEEP_REQUEST;

endmodule // sbs_sram_port

`default_nettype wire

// ---- sbs_port_checker.sv ----
// Concurrent checks on the SRAM port pins
`timescale 1ns/1ps
`default_nettype none
module sbs_port_checker (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic PRIMARY_SELECT_N,
  input wire logic SECOND_SELECT_N,
  input wire logic THIRD_SELECT,
  input wire logic SLEEP_REQUEST,
  input wire logic OUTPUT_DRIVE_N,
  input wire logic PROC_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic DATA_OE_N,
  input wire logic BURST_ACTIVE,
  input wire logic STANDBY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // Live edges; sleep or a stopped clock hides every strobe
  wire logic live = CLK_EN && !SLEEP_REQUEST;
  wire logic sel = !PRIMARY_SELECT_N && !SECOND_SELECT_N && THIRD_SELECT;
  wire logic pload = live && !PROC_ADDR_STROBE_N && !PRIMARY_SELECT_N;
  wire logic cload = live && !CTRL_ADDR_STROBE_N && !pload;
  property p_oe_drive; OUTPUT_DRIVE_N |-> DATA_OE_N; endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("oe not off");
  property p_oe_sleep; SLEEP_REQUEST |-> DATA_OE_N; endproperty
  a_oe_sleep: assert property (p_oe_sleep) else $error("oe on in sleep");
  property p_standby; SLEEP_REQUEST && CLK_EN |=> STANDBY; endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  property p_load_sel; (pload || cload) && sel |=> BURST_ACTIVE; endproperty
  a_load_sel: assert property (p_load_sel) else $error("load not selected");
  property p_ctrl_down; cload && PRIMARY_SELECT_N |=> !BURST_ACTIVE; endproperty
  a_ctrl_down: assert property (p_ctrl_down) else $error("ctrl no powerdown");
  property p_proc_down; pload && (SECOND_SELECT_N || !THIRD_SELECT) |=> !BURST_ACTIVE; endproperty
  a_proc_down: assert property (p_proc_down) else $error("proc no powerdown");
  property p_proc_ign;
    live && !STANDBY && !PROC_ADDR_STROBE_N && PRIMARY_SELECT_N && CTRL_ADDR_STROBE_N
      |=> $stable(BURST_ACTIVE);
  endproperty
  a_proc_ign: assert property (p_proc_ign) else $error("proc strobe acted");
  // A selected processor load shows its word two edges on, if the edge between has the clock enabled and no sleep
  property p_read_lat;
    pload && sel ##1 live ##1 (!OUTPUT_DRIVE_N && !SLEEP_REQUEST) |-> !DATA_OE_N;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read not shown");
endmodule  // sbs_port_checker

bind sbs_sram_port sbs_port_checker chk_u (.MCLK, .RST_B, .CLK_EN, .PRIMARY_SELECT_N,
  .SECOND_SELECT_N, .THIRD_SELECT, .SLEEP_REQUEST, .OUTPUT_DRIVE_N, .PROC_ADDR_STROBE_N,
  .CTRL_ADDR_STROBE_N, .DATA_OE_N, .BURST_ACTIVE, .STANDBY);
`default_nettype wire

// ---- sbs_ctl_model.sv ----
// Bus master model driving the SRAM port inputs one cycle at a time
`timescale 1ns/1ps
`default_nettype none
module sbs_ctl_model
  import sbs_pkg::*;
(
  input wire logic mclk,
  output logic [11:0] ctl,
  output sbs_addr_t addr,
  output sbs_word_t din
);
  // Idle: strobes and selects off, no advance, every write enable high
  initial begin
    ctl = 12'hf7f;
    addr = '0;
    din = '0;
  end
  // Change after the falling edge, hold through the rising edge that samples it
  task automatic cyc(input logic [7:0] k, input logic [3:0] l, input sbs_addr_t a,
                     input sbs_word_t d);
    @(negedge mclk);
    ctl = {k, l};
    addr = a;
    din = d;
    @(posedge mclk);
  endtask
endmodule  // sbs_ctl_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the SRAM port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbs_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic sleep = 1'b0;
  logic drive_n = 1'b0;
  logic order = 1'b0;
  logic clk_en = 1'b1;
  logic oe_n, stby, busy;
  logic [11:0] ctl;
  sbs_addr_t addr, base;
  sbs_word_t din, dout;
  sbs_word_t shadow [sbs_addr_t];
  sbs_word_t exp_q [$];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'h54e7fdf9;

  sbs_ctl_model ctl_u (.mclk, .ctl, .addr, .din);
  sbs_sram_port dut_u (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en), .ADDR_BIT_ZERO(addr[0]),
    .ADDR_BIT_ONE(addr[1]), .ADDR_UPPER_BITS(addr[16:2]), .LANE_A_WRITE_N(ctl[0]),
    .LANE_B_WRITE_N(ctl[1]), .LANE_C_WRITE_N(ctl[2]), .LANE_D_WRITE_N(ctl[3]),
    .LANE_WRITE_GATE_N(ctl[4]), .FULL_WRITE_N(ctl[5]), .BURST_STEP_N(ctl[6]),
    .THIRD_SELECT(ctl[7]), .SECOND_SELECT_N(ctl[8]), .PRIMARY_SELECT_N(ctl[9]),
    .CTRL_ADDR_STROBE_N(ctl[10]), .PROC_ADDR_STROBE_N(ctl[11]), .SLEEP_REQUEST(sleep),
    .OUTPUT_DRIVE_N(drive_n), .BURST_ORDER(order), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_N(oe_n), .BURST_ACTIVE(busy), .STANDBY(stby));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  // Burst low bits of step c, worked out apart from the design
  function automatic logic [1:0] lo(input logic [1:0] s, input logic [1:0] c);
    return order ? (s ^ c) : 2'(s + c);
  endfunction
  // Bit enables of written lanes, each byte with its parity bit
  function automatic sbs_word_t bmask(input logic [3:0] l);
    sbs_word_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{l[i]}};
      m[32+i] = l[i];
    end
    return m;
  endfunction

  task automatic chk(input string n, input sbs_word_t e, input sbs_word_t s);
    checks_done++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask

  // Controller-strobe write, then a deselecting strobe so no burst reads follow
  task automatic wr(input sbs_addr_t a, input logic f, input logic g, input logic [3:0] l);
    sbs_word_t d, m;
    d = sbs_word_t'({$random(seed), $random(seed)});
    m = bmask(!f ? 4'hf : (!g ? ~l : 4'h0));
    ctl_u.cyc({6'b100011, f, g}, l, a, d);
    if (!sleep && clk_en) shadow[a] = (shadow[a] & ~m) | (d & m);
    // With no lane enabled the controller strobe reads instead
    if (!sleep && clk_en && m == '0) exp_q.push_back(shadow[a]);
    ctl_u.cyc(8'haf, 4'hf, a, ~d);
  endtask

  // Processor-strobe read, four continuation cycles with random advance
  task automatic rd(input sbs_addr_t a);
    logic [1:0] c;
    logic s;
    c = 2'h0;
    ctl_u.cyc(8'h4f, 4'hf, a, '0);
    exp_q.push_back(shadow[a]);
    repeat (4) begin
      s = 1'($random(seed));
      // Address and primary select wander once the address is loaded
      ctl_u.cyc({5'b11101, s, 2'b11}, 4'hf, ~a, '0);
      c = c + {1'b0, !s};
      exp_q.push_back(shadow[{a[16:2], lo(a[1:0], c)}]);
    end
    ctl_u.cyc(8'haf, 4'hf, a, '0);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("burst idle", 36'h0, 36'(busy));
  endtask

  // Processor-strobe read, then a full write on the held address with step high
  task automatic pw(input sbs_addr_t a);
    sbs_word_t d;
    d = sbs_word_t'({$random(seed), $random(seed)});
    ctl_u.cyc(8'h4f, 4'hf, a, '0);
    exp_q.push_back(shadow[a]);
    ctl_u.cyc(8'hed, 4'hf, ~a, d);
    shadow[a] = d;
    // The idle gap repeats the same write on the same address, which changes nothing
    @(negedge mclk);
    chk("burst", 36'h1, 36'(busy));
    ctl_u.cyc(8'haf, 4'hf, a, '0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each read shows as one cycle of enabled outputs; looked at mid-cycle where it has settled
  always @(negedge mclk) begin
    if (rst_b && oe_n === 1'b0) begin
      if (exp_q.size() > 0) chk("read data", exp_q.pop_front(), dout);
      else chk("read count", 36'h0, 36'h1);
    end
  end

  // Hang guard, far above the roughly 130 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    for (int o = 0; o < 2; o++) begin
      @(negedge mclk);
      rst_b = 1'b0;
      order = o[0];
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      base = sbs_addr_t'($random(seed)) & ~17'h3;
      for (int i = 0; i < 4; i++) wr(base + 17'(i), 1'b0, 1'b1, 4'hf);
      wr(base + 17'h1, 1'b1, 1'b0, 4'($random(seed)));
      wr(base + 17'h2, 1'b1, 1'b1, 4'h0);
      // Refused processor strobes: primary off, then third select low
      ctl_u.cyc(8'h6f, 4'hf, base, '0);
      ctl_u.cyc(8'h47, 4'hf, base, '0);
      pw(base + 17'h3);
      rd(base + 17'($random(seed) & 3));
      // A write in sleep is dropped and the outputs stay off
      @(negedge mclk);
      sleep = 1'b1;
      drive_n = 1'b1;
      wr(base, 1'b0, 1'b1, 4'hf);
      @(negedge mclk);
      chk("standby", 36'h1, 36'(stby));
      chk("oe_n", 36'h1, 36'(oe_n));
      sleep = 1'b0;
      drive_n = 1'b0;
      // Clock enable low freezes the port, so this write is lost as well
      clk_en = 1'b0;
      wr(base, 1'b0, 1'b1, 4'hf);
      @(negedge mclk);
      chk("frozen standby", 36'h1, 36'(stby));
      clk_en = 1'b1;
      rd(base);
    end
    repeat (4) @(negedge mclk);
    chk("pending", 36'h0, 36'(exp_q.size()));
    finish_test();
  end
endmodule  // tb
`default_nettype wire
